/* File: hdl/ccgp_clock_ctrl.sv */
/*
 * Clock generator control: high-speed clock select with a doubling PLL,
 * gear and prescaler dividers, low-power mode code, warm-up and PLL init
 * timers, and a key that guards register writes. All clocks are modelled
 * as one-cycle enables on i_clk.
 * Assumes an APB master on i_clk and a power controller that pulses
 * i_deep_stop_wakeup on i_clk when the part leaves the deep stop mode.
 */
`timescale 1ns/10ps
`default_nettype none
module ccgp_clock_ctrl
    import ccgp_pkg::*;
#(
    parameter int PLL_INIT_COUNT = ccgp_pkg::PLL_INIT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_deep_stop_wakeup,
    output logic o_high_speed_clock_en,
    output logic o_system_clock_en,
    output logic o_peripheral_clock_en,
    output logic o_prescaler_clock_en,
    output logic [2:0] o_low_power_mode_code,
    output logic o_internal_oscillator_enable,
    output logic o_external_oscillator_enable,
    output logic o_oscillator_source_select,
    output logic o_multiplier_run_control,
    output logic o_multiplied_clock_status
);
    typedef struct packed {
        logic [2:0] gear;
        logic [2:0] prescaler_select;
        logic [2:0] peripheral_clock_select;
        logic [11:0] warmup_count;
        logic warmup_clock_select;
        logic ext_source_select;
        logic oscillator_source_select;
        logic internal_oscillator_enable;
        logic external_oscillator_enable;
        logic multiplier_run_control;
        logic [2:0] low_power_mode_code;
        logic [14:0] multiplier;
        logic multiplied_clock_use;
        logic [7:0] write_key;
        logic osc_phase;
        logic multiplied_clock_status;
        logic high_speed_en;
        logic peripheral_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic warmup_start;
        logic init_start;
    } ccgp_state_t;

    ccgp_state_t state_reg;
    ccgp_state_t state_next;
    logic wr_access;
    logic key_open;
    logic osc_running;
    logic osc_tick;
    logic pll_tick;
    logic pll_ready;
    logic warmup_tick;
    logic warmup_busy;
    logic init_busy;
    logic system_en;
    logic prescaler_en;
    logic [31:0] read_word;
    logic addr_known;

    ////////////////////////////////////////////////////////////////////////
    // Clock sources as enables.

    // The oscillator clock ticks every other cycle so that the doubled clock
    // can tick every cycle and still be an exact multiple of it.
    assign osc_running = state_reg.oscillator_source_select ?
        state_reg.external_oscillator_enable : state_reg.internal_oscillator_enable;
    assign osc_tick = osc_running && state_reg.osc_phase;
    // The PLL only delivers once it is running and its init period is over.
    assign pll_ready = state_reg.multiplier_run_control && !init_busy;
    assign pll_tick = pll_ready && osc_running;
    assign warmup_tick = state_reg.osc_phase && (state_reg.warmup_clock_select ?
        state_reg.external_oscillator_enable : state_reg.internal_oscillator_enable);
    assign wr_access = i_psel && i_penable && state_reg.pready && i_pwrite;
    assign key_open = (state_reg.write_key == WRITE_KEY_ENABLE);

    ////////////////////////////////////////////////////////////////////////
    // Register read image.

    always_comb begin
        read_word = 32'h0000_0000;
        addr_known = 1'b1;
        unique case (i_paddr)
            OFS_SYSTEM_CLOCK_CONTROL: begin
                read_word[GEAR_LSB +: 3] = state_reg.gear;
                read_word[PRESCALER_SELECT_LSB +: 3] = state_reg.prescaler_select;
                read_word[PERIPHERAL_CLOCK_SELECT_LSB +: 3] = state_reg.peripheral_clock_select;
            end
            OFS_OSCILLATOR_CONTROL: begin
                read_word[WARMUP_ACTIVE_BIT] = warmup_busy;
                read_word[RUN_CONTROL_BIT] = state_reg.multiplier_run_control;
                read_word[FIXED_FIELD_LSB +: 5] = FIXED_FIELD_VALUE;
                read_word[EXT_OSC_ENABLE_BIT] = state_reg.external_oscillator_enable;
                read_word[OSC_STATUS_BIT] = state_reg.oscillator_source_select;
                read_word[INT_OSC_ENABLE_BIT] = state_reg.internal_oscillator_enable;
                read_word[OSC_SOURCE_SELECT_BIT] = state_reg.oscillator_source_select;
                read_word[EXT_SOURCE_SELECT_BIT] = state_reg.ext_source_select;
                read_word[WARMUP_CLOCK_SELECT_BIT] = state_reg.warmup_clock_select;
                read_word[WARMUP_COUNT_LSB +: 12] = state_reg.warmup_count;
            end
            OFS_LOW_POWER_MODE_CONTROL: begin
                read_word[2:0] = state_reg.low_power_mode_code;
            end
            OFS_PLL_SELECTION: begin
                read_word[MULTIPLIED_USE_BIT] = state_reg.multiplied_clock_use;
                read_word[MULTIPLIER_LSB +: 15] = state_reg.multiplier;
                read_word[MULTIPLIED_STATUS_BIT] = state_reg.multiplied_clock_status;
            end
            OFS_CLOCK_REGISTER_WRITE_KEY: begin
                read_word[7:0] = state_reg.write_key;
            end
            default: begin
                addr_known = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        state_next = state_reg;
        state_next.warmup_start = 1'b0;
        state_next.init_start = 1'b0;
        state_next.osc_phase = !state_reg.osc_phase;
        // Zero-wait answer: data latched in setup, pready high in access.
        state_next.pready = i_psel && !i_penable;
        state_next.pslverr = i_psel && !i_penable && !addr_known;
        if (i_psel && !i_penable) begin
            state_next.prdata = read_word;
        end
        if (wr_access && i_paddr == OFS_CLOCK_REGISTER_WRITE_KEY) begin
            state_next.write_key = i_pwdata[7:0];
        end
        if (wr_access && key_open) begin
            unique case (i_paddr)
                OFS_SYSTEM_CLOCK_CONTROL: begin
                    state_next.gear = i_pwdata[GEAR_LSB +: 3];
                    state_next.prescaler_select = i_pwdata[PRESCALER_SELECT_LSB +: 3];
                    state_next.peripheral_clock_select =
                        i_pwdata[PERIPHERAL_CLOCK_SELECT_LSB +: 3];
                end
                OFS_OSCILLATOR_CONTROL: begin
                    state_next.warmup_start = i_pwdata[WARMUP_START_BIT];
                    state_next.multiplier_run_control = i_pwdata[RUN_CONTROL_BIT];
                    state_next.external_oscillator_enable = i_pwdata[EXT_OSC_ENABLE_BIT];
                    state_next.internal_oscillator_enable = i_pwdata[INT_OSC_ENABLE_BIT];
                    state_next.oscillator_source_select = i_pwdata[OSC_SOURCE_SELECT_BIT];
                    state_next.ext_source_select = i_pwdata[EXT_SOURCE_SELECT_BIT];
                    state_next.warmup_clock_select = i_pwdata[WARMUP_CLOCK_SELECT_BIT];
                    state_next.warmup_count = i_pwdata[WARMUP_COUNT_LSB +: 12];
                end
                OFS_LOW_POWER_MODE_CONTROL: begin
                    state_next.low_power_mode_code = i_pwdata[2:0];
                end
                OFS_PLL_SELECTION: begin
                    state_next.multiplied_clock_use = i_pwdata[MULTIPLIED_USE_BIT];
                    // Any write here restarts the init period, even with an unchanged multiplier.
                    state_next.multiplier = i_pwdata[MULTIPLIER_LSB +: 15];
                    state_next.init_start = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // Leaving deep stop overrides a write landing in the same cycle.
        if (i_deep_stop_wakeup) begin
            state_next.warmup_clock_select = 1'b0;
            state_next.oscillator_source_select = 1'b0;
            state_next.internal_oscillator_enable = 1'b1;
            state_next.external_oscillator_enable = 1'b0;
            state_next.multiplier_run_control = 1'b0;
            state_next.multiplied_clock_use = 1'b0;
        end
        // Source changes only at an oscillator tick, where both enables are
        // high together, so no tick is ever cut short or doubled.
        if (state_reg.osc_phase) begin
            state_next.multiplied_clock_status =
                state_reg.multiplied_clock_use && pll_ready;
        end
        state_next.high_speed_en = state_reg.multiplied_clock_status ?
            pll_tick : osc_tick;
        // Code 000 feeds peripherals from the gear clock, else from fast clock.
        state_next.peripheral_en = (state_reg.peripheral_clock_select == 3'h0) ?
            system_en : state_reg.high_speed_en;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and dividers.

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= '0;
            state_reg.gear <= GEAR_RESET;
            state_reg.prescaler_select <= PRESCALER_RESET;
            state_reg.peripheral_clock_select <= PERIPHERAL_SELECT_RESET;
            state_reg.internal_oscillator_enable <= 1'b1;
            state_reg.low_power_mode_code <= LOW_POWER_MODE_RESET;
            state_reg.multiplier <= MULTIPLIER_RESET;
            state_reg.write_key <= WRITE_KEY_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ccgp_divider u_gear_div (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(state_reg.high_speed_en),
        .i_shift(ccgp_gear_shift(state_reg.gear)),
        .o_pulse(system_en)
    );

    ccgp_divider u_prescaler_div (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(state_reg.peripheral_en),
        .i_shift(ccgp_prescaler_shift(state_reg.prescaler_select)),
        .o_pulse(prescaler_en)
    );

    ccgp_timer u_warmup_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_start(state_reg.warmup_start),
        .i_tick(warmup_tick),
        .i_load({state_reg.warmup_count, 4'h0}),
        .o_busy(warmup_busy)
    );

    ccgp_timer u_init_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_start(state_reg.init_start),
        .i_tick(1'b1),
        .i_load(TIMER_WIDTH'(PLL_INIT_COUNT)),
        .o_busy(init_busy)
    );

    assign o_prdata = state_reg.prdata;
    assign o_pready = state_reg.pready;
    assign o_pslverr = state_reg.pslverr;
    assign o_high_speed_clock_en = state_reg.high_speed_en;
    assign o_system_clock_en = system_en;
    assign o_peripheral_clock_en = state_reg.peripheral_en;
    assign o_prescaler_clock_en = prescaler_en;
    assign o_low_power_mode_code = state_reg.low_power_mode_code;
    assign o_internal_oscillator_enable = state_reg.internal_oscillator_enable;
    assign o_external_oscillator_enable = state_reg.external_oscillator_enable;
    assign o_oscillator_source_select = state_reg.oscillator_source_select;
    assign o_multiplier_run_control = state_reg.multiplier_run_control;
    assign o_multiplied_clock_status = state_reg.multiplied_clock_status;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence apb_write_s(logic [7:0] ofs);
        wr_access && i_paddr == ofs;
    endsequence

    sequence locked_write_s(logic [7:0] ofs);
        apb_write_s(ofs) ##0 !key_open;
    endsequence

    key_blocks_gear_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        locked_write_s(OFS_SYSTEM_CLOCK_CONTROL) |=> $stable(state_reg.gear))
        else $error("Gear changed through a locked key.");

    key_always_written_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        apb_write_s(OFS_CLOCK_REGISTER_WRITE_KEY) |=> state_reg.write_key == $past(i_pwdata[7:0]))
        else $error("Key register did not take a write.");

    mode_code_write_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        apb_write_s(OFS_LOW_POWER_MODE_CONTROL) ##0 key_open
        |=> o_low_power_mode_code == $past(i_pwdata[2:0]))
        else $error("Low-power mode code not written.");

    status_at_boundary_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        $rose(o_multiplied_clock_status) |-> $past(state_reg.osc_phase)
            && $past(state_reg.multiplied_clock_use) && $past(pll_ready))
        else $error("Multiplied status rose off a boundary or unready.");

    osc_source_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !state_reg.multiplied_clock_status ##1 1'b1 |-> o_high_speed_clock_en == $past(osc_tick))
        else $error("High-speed clock not following the oscillator.");

    doubled_rate_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (state_reg.multiplied_clock_status && pll_tick) [*3] |=> o_high_speed_clock_en
            && $past(o_high_speed_clock_en) && $past(o_high_speed_clock_en, 2))
        else $error("Multiplied clock not ticking every cycle.");

    wakeup_restore_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_deep_stop_wakeup |=> o_internal_oscillator_enable && !o_external_oscillator_enable
            && !o_multiplier_run_control && !state_reg.multiplied_clock_use
            && !o_oscillator_source_select)
        else $error("Deep stop return did not restore clock bits.");

    init_hold_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        state_reg.init_start |=> init_busy && !pll_ready)
        else $error("PLL ready during its init period.");

    warmup_flag_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        apb_write_s(OFS_OSCILLATOR_CONTROL) ##0 key_open && i_pwdata[0]
            && i_pwdata[WARMUP_COUNT_LSB +: 12] != 12'h000 |-> ##2 warmup_busy)
        else $error("Warm-up flag not set after start.");

    run_stop_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !o_multiplier_run_control [*2] |-> ##[0:2] !o_multiplied_clock_status)
        else $error("Multiplied clock kept with the PLL stopped.");
endmodule
`default_nettype wire

/* File: hdl/ccgp_pkg.sv */
/*
 * Package of the clock generator control block: register offsets, field
 * positions, reset values, mode codes and timing counts.
 * Assumes a 125 MHz block clock and a 32-bit APB register port.
 */
package ccgp_pkg;
    // Register byte offsets on the APB port.
    localparam logic [7:0] OFS_SYSTEM_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OSCILLATOR_CONTROL = 8'h04;
    localparam logic [7:0] OFS_LOW_POWER_MODE_CONTROL = 8'h08;
    localparam logic [7:0] OFS_PLL_SELECTION = 8'h0C;
    localparam logic [7:0] OFS_CLOCK_REGISTER_WRITE_KEY = 8'h10;

    // System clock control fields.
    localparam int GEAR_LSB = 0;
    localparam int PRESCALER_SELECT_LSB = 8;
    localparam int PERIPHERAL_CLOCK_SELECT_LSB = 12;

    // Oscillator control fields.
    localparam int WARMUP_START_BIT = 0;
    localparam int WARMUP_ACTIVE_BIT = 1;
    localparam int RUN_CONTROL_BIT = 2;
    localparam int FIXED_FIELD_LSB = 3;
    localparam int EXT_OSC_ENABLE_BIT = 8;
    localparam int OSC_STATUS_BIT = 9;
    localparam int INT_OSC_ENABLE_BIT = 16;
    localparam int OSC_SOURCE_SELECT_BIT = 17;
    localparam int EXT_SOURCE_SELECT_BIT = 18;
    localparam int WARMUP_CLOCK_SELECT_BIT = 19;
    localparam int WARMUP_COUNT_LSB = 20;

    // PLL selection fields.
    localparam int MULTIPLIED_USE_BIT = 0;
    localparam int MULTIPLIER_LSB = 1;
    localparam int MULTIPLIED_STATUS_BIT = 18;

    // Reset values and codes.
    localparam logic [2:0] GEAR_RESET = 3'h0;
    localparam logic [2:0] PRESCALER_RESET = 3'h0;
    localparam logic [2:0] PERIPHERAL_SELECT_RESET = 3'h0;
    localparam logic [4:0] FIXED_FIELD_VALUE = 5'h06;
    localparam logic [2:0] MODE_DEEP_STOP = 3'h1;
    localparam logic [2:0] MODE_IDLE = 3'h3;
    localparam logic [2:0] LOW_POWER_MODE_RESET = MODE_IDLE;
    localparam logic [14:0] MULTIPLIER_DOUBLE = 15'h609F;
    localparam logic [14:0] MULTIPLIER_RESET = 15'h0000;
    localparam logic [7:0] WRITE_KEY_ENABLE = 8'hC1;
    localparam logic [7:0] WRITE_KEY_RESET = WRITE_KEY_ENABLE;

    // Timing.
    localparam int CLOCK_MHZ = 125;
    localparam int PLL_INIT_TIME_US = 100;
    localparam int PLL_INIT_CYCLES = PLL_INIT_TIME_US * CLOCK_MHZ;
    localparam int TIMER_WIDTH = 16;
    localparam int DIVIDER_WIDTH = 5;

    // Gear code to power-of-two divide; reserved codes divide by one.
    function automatic logic [2:0] ccgp_gear_shift(input logic [2:0] code);
        unique case (code)
            3'h4: ccgp_gear_shift = 3'h1;
            3'h5: ccgp_gear_shift = 3'h2;
            3'h6: ccgp_gear_shift = 3'h3;
            3'h7: ccgp_gear_shift = 3'h4;
            default: ccgp_gear_shift = 3'h0;
        endcase
    endfunction

    // Prescaler code to power-of-two divide; reserved codes divide by one.
    function automatic logic [2:0] ccgp_prescaler_shift(input logic [2:0] code);
        ccgp_prescaler_shift = (code > 3'h5) ? 3'h0 : code;
    endfunction
endpackage

/* File: hdl/ccgp_divider.sv */
/*
 * Power-of-two enable divider: passes one input tick in every 2**shift.
 * Assumes i_tick is a one-cycle enable on i_clk and shift is at most 4 or 5.
 */
`timescale 1ns/10ps
`default_nettype none
module ccgp_divider
    import ccgp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic [2:0] i_shift,
    output logic o_pulse
);
    typedef struct packed {
        logic [DIVIDER_WIDTH-1:0] count;
        logic pulse;
    } ccgp_div_state_t;

    ccgp_div_state_t state_reg;
    ccgp_div_state_t state_next;
    logic [DIVIDER_WIDTH-1:0] mask;

    always_comb begin
        mask = DIVIDER_WIDTH'((DIVIDER_WIDTH'(1) << i_shift) - DIVIDER_WIDTH'(1));
        state_next = state_reg;
        state_next.pulse = i_tick && ((state_reg.count & mask) == mask);
        if (i_tick) begin
            state_next.count = state_reg.count + DIVIDER_WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_pulse = state_reg.pulse;
endmodule
`default_nettype wire

/* File: hdl/ccgp_timer.sv */
/*
 * Down-counting timer: loads a count on start, counts ticks, busy until zero.
 * Assumes i_start and i_tick are enables from logic on i_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module ccgp_timer
    import ccgp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_tick,
    input wire logic [TIMER_WIDTH-1:0] i_load,
    output logic o_busy
);
    typedef struct packed {
        logic [TIMER_WIDTH-1:0] count;
    } ccgp_tmr_state_t;

    ccgp_tmr_state_t state_reg;
    ccgp_tmr_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (i_start) begin
            state_next.count = i_load;
        end else if (i_tick && state_reg.count != '0) begin
            state_next.count = state_reg.count - TIMER_WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_busy = (state_reg.count != '0);
endmodule
`default_nettype wire

/* File: test/ccgp_testbench.sv */
/*
 * Register-level bench of the clock generator control block.
 * Assumes a zero-wait APB slave and the enables of the top module ports.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ccgp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, wake = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdat = 32'h0, q;
    logic [31:0] rdat;
    logic rdy, serr, err;
    logic [3:0] en;
    logic [2:0] mode;
    logic ien, xen, osel, run, stat;
    int fails = 0, checked = 0, p;
    int gval[9] = '{32'h0, 32'h4, 32'h5, 32'h6, 32'h7, 32'h500, 32'h600, 32'h4, 32'h1004};
    int gsel[9] = '{1, 1, 1, 1, 1, 3, 3, 2, 2};
    int gexp[9] = '{2, 4, 8, 16, 32, 64, 2, 4, 2};
    ccgp_clock_ctrl #(.PLL_INIT_COUNT(20)) ccgp_clock_ctrl_inst (.i_clk(clk), .i_reset(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
        .o_prdata(rdat), .o_pready(rdy), .o_pslverr(serr), .i_deep_stop_wakeup(wake),
        .o_high_speed_clock_en(en[0]), .o_system_clock_en(en[1]),
        .o_peripheral_clock_en(en[2]), .o_prescaler_clock_en(en[3]),
        .o_low_power_mode_code(mode), .o_internal_oscillator_enable(ien),
        .o_external_oscillator_enable(xen), .o_oscillator_source_select(osel),
        .o_multiplier_run_control(run), .o_multiplied_clock_status(stat));
    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; addr <= a; wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        q = rdat; err = serr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    // The second interval is taken so a divider change has settled.
    task automatic period(input int s);
        repeat (2) begin
            p = 0;
            while (en[s] !== 1'b1) @(posedge clk);
            do begin
                @(posedge clk);
                p++;
            end while (en[s] !== 1'b1 && p < 200);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(0, 8'h08, 0); chk("mode", q, 32'h3);
        apb(0, 8'h10, 0); chk("key", q, 32'hC1);
        apb(0, 8'h0C, 0); chk("multiplied_clock_use", q, 32'h0);
        apb(0, 8'h04, 0); chk("osc", q, 32'h00010030);
        period(0); chk("hs", p, 2);
        period(1); chk("sys", p, 2);
        period(2); chk("per", p, 2);
        period(3); chk("pre", p, 2);
        $display("test reset done");
        apb(1, 8'h08, 32'h1);
        @(posedge clk);
        chk("mode_out", mode, 3'h1);
        apb(1, 8'h10, 32'h0);
        apb(1, 8'h00, 32'h4);
        apb(0, 8'h00, 0); chk("blocked_gear", q, 32'h0);
        apb(1, 8'h08, 32'h3); chk("blocked_err", err, 1'b0);
        apb(0, 8'h08, 0); chk("blocked", q, 32'h1);
        apb(1, 8'h10, 32'hC1);
        apb(0, 8'h14, 0); chk("unmapped", {err, q[30:0]}, 32'h80000000);
        $display("test key done");
        for (int i = 0; i < 9; i++) begin
            apb(1, 8'h00, gval[i]);
            period(gsel[i]); chk("divide", p, gexp[i]);
        end
        apb(1, 8'h00, 0);
        $display("test divide done");
        apb(1, 8'h0C, 32'h0000C13E);
        apb(1, 8'h04, 32'h00030134);
        repeat (40) @(posedge clk);
        apb(1, 8'h0C, 32'h0000C13F);
        // Rewriting the multiplier restarts the init period, so wait it out again.
        repeat (30) @(posedge clk);
        apb(0, 8'h0C, 0); chk("pll_on", q, 32'h0004C13F);
        period(0); chk("hs_pll", p, 1);
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        repeat (4) @(posedge clk);
        apb(0, 8'h0C, 0); chk("wake_pll", q, 32'h0000C13E);
        apb(0, 8'h04, 0); chk("wake_osc", q, 32'h00010030);
        chk("wake_pins", {ien, xen, osel, run, stat}, 5'h10);
        apb(1, 8'h04, 32'h00110031);
        apb(0, 8'h04, 0); chk("warm_busy", q, 32'h00110032);
        repeat (50) @(posedge clk);
        apb(0, 8'h04, 0); chk("warm_done", q, 32'h00110030);
        $display("test pll done");
        finish_test();
    end
endmodule
`default_nettype wire
